//--- logic/psfp_pkg.sv
package psfp_pkg;
  localparam int CLK_HZ = 10_000_000;
  // Latched shutoff clears after command low this long
  localparam int LATCH_CLR_US = 350;
  localparam int LATCH_CLR_CYC = (LATCH_CLR_US * (CLK_HZ / 1_000_000)) + 1;
  // Wake-up time after low-power release
  localparam int WAKE_MS = 1;
  localparam int WAKE_CYC = WAKE_MS * (CLK_HZ / 1_000);
  // Cycle-by-cycle limited pulses allowed in a row
  localparam logic [3:0] CBC_MAX_RUN = 4'h4;
  // Switching period, soft-start duty and duty step per period, in clock cycles
  localparam logic [7:0] PERIOD_CYC = 8'h64;
  localparam logic [7:0] SOFT_STEP = 8'h02;
  localparam logic [7:0] SOFT_START_DUTY = 8'h02;
  localparam logic [12:0] LATCH_CLR_CNT = 13'(LATCH_CLR_CYC);
  localparam logic [13:0] WAKE_CNT = 14'(WAKE_CYC);

  typedef enum logic [1:0] {
    PSFP_BUCK,
    PSFP_BOOST
  } psfp_mode_t;

  typedef struct packed {
    logic enable;
    logic latched_variant;
    psfp_mode_t mode;
    logic [7:0] duty;
  } psfp_ctrl_t;

  typedef struct packed {
    logic hs_cmd;
    logic ls_cmd;
    logic speedup;
    logic low_power_request;
  } psfp_drive_t;

  typedef struct packed {
    logic running;
    logic starting;
    logic waking;
    logic fault_seen;
    logic latched_shutdown;
  } psfp_stat_t;
endpackage

//--- logic/psfp_ctrl.sv
// Behaviour
// - Limit consecutive limited cycles, cut pulses
// - Buck start: low side on until ready
// - Boost start: tiny duty, ramp gradually
// - Speed-up gate only after high-side ready
module psfp_ctrl (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire psfp_pkg::psfp_ctrl_t ctrl_in,
  input wire logic hs_ready_in,
  input wire logic ls_ready_in,
  output psfp_pkg::psfp_drive_t drive_out,
  output psfp_pkg::psfp_stat_t stat_out
);
  import psfp_pkg::*;

  typedef enum logic [2:0] {
    S_SLEEP,
    S_WAKE,
    S_PRECHARGE,
    S_SOFT,
    S_RUN,
    S_CLEAR
  } psfp_state_t;

  typedef struct packed {
    psfp_state_t st;
    logic [7:0] phase;
    logic [7:0] duty;
    logic [13:0] timer;
    logic [3:0] cbc_run;
    logic hs_rdy_q;
    logic cut;
    psfp_drive_t drv;
    psfp_stat_t stat;
  } psfp_regs_t;

  psfp_regs_t s_r;
  psfp_regs_t s_nxt;

  function automatic logic [7:0] sat_add(input logic [7:0] a,
                                         input logic [7:0] b);
    logic [8:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    sat_add = sum[8] ? 8'hFF : sum[7:0];
  endfunction

  function automatic logic is_starting(input psfp_state_t st);
    is_starting = (st == S_PRECHARGE) || (st == S_SOFT);
  endfunction

  function automatic logic [7:0] next_phase(input logic [7:0] ph,
                                            input logic wrap);
    next_phase = wrap ? 8'h00 : ph + 8'h01;
  endfunction

  // Latched parts stop on the first trip; others after a run of limited pulses
  function automatic logic cbc_limit_hit(input logic [3:0] run,
                                         input logic latched);
    cbc_limit_hit = latched || (run + 4'h1 >= CBC_MAX_RUN);
  endfunction

  logic [7:0] duty_cap;
  logic pulse_hi;
  logic ready_fall;
  logic period_end;
  logic trip;
  logic wake_done;
  logic clear_done;

  always_comb begin
    // Duty above one period clamps
    duty_cap = (ctrl_in.duty < PERIOD_CYC) ? ctrl_in.duty : PERIOD_CYC;
    pulse_hi = (s_r.phase < s_r.duty);
    // Last cycle of the switching period
    period_end = (s_r.phase == PERIOD_CYC - 8'h01);
    // Ready low in mid-pulse: device tripped, lockout or overheated
    ready_fall = s_r.hs_rdy_q && !hs_ready_in;
    // A trip only counts while the high side was commanded on
    trip = (s_r.st == S_RUN) && ready_fall && s_r.drv.hs_cmd;
    wake_done = (s_r.timer >= WAKE_CNT);
    clear_done = (s_r.timer >= {1'b0, LATCH_CLR_CNT});

    s_nxt = s_r;
    s_nxt.hs_rdy_q = hs_ready_in;
    s_nxt.phase = next_phase(s_r.phase, period_end);
    s_nxt.drv.low_power_request = 1'b1;
    s_nxt.drv.hs_cmd = 1'b0;
    s_nxt.drv.ls_cmd = 1'b0;
    // Slow edges until both the high side and the low side report ready
    s_nxt.drv.speedup = hs_ready_in && ls_ready_in;

    unique case (s_r.st)
      S_SLEEP: begin
        // Devices kept in low-power mode while disabled
        s_nxt.drv.low_power_request = 1'b0;
        s_nxt.timer = '0;
        if (ctrl_in.enable) begin
          s_nxt.st = S_WAKE;
        end
      end
      S_WAKE: begin
        s_nxt.timer = s_r.timer + 14'h0001;
        // Device needs the full wake time before it may switch
        if (!ctrl_in.enable) begin
          s_nxt.st = S_SLEEP;
        end else if (wake_done) begin
          s_nxt.timer = '0;
          s_nxt.duty = SOFT_START_DUTY;
          s_nxt.phase = '0;
          s_nxt.st = (ctrl_in.mode == PSFP_BUCK) ? S_PRECHARGE : S_SOFT;
        end
      end
      S_PRECHARGE: begin
        s_nxt.drv.ls_cmd = 1'b1;
        if (!ctrl_in.enable) begin
          s_nxt.st = S_SLEEP;
        end else if (hs_ready_in) begin
          s_nxt.duty = duty_cap;
          s_nxt.phase = '0;
          s_nxt.st = S_RUN;
        end
      end
      S_SOFT: begin
        // Boost: the low side is the main switch
        s_nxt.drv.hs_cmd = 1'b0;
        s_nxt.drv.ls_cmd = pulse_hi && ls_ready_in;
        if (!ctrl_in.enable) begin
          s_nxt.st = S_SLEEP;
        end else if (period_end) begin
          s_nxt.duty = sat_add(s_r.duty, SOFT_STEP);
          if (hs_ready_in && s_nxt.duty >= duty_cap) begin
            s_nxt.duty = duty_cap;
            s_nxt.st = S_RUN;
          end
        end
      end
      S_RUN: begin
        if (period_end) begin
          s_nxt.duty = duty_cap;
          s_nxt.cut = 1'b0;
          if (!s_r.cut) begin
            s_nxt.cbc_run = '0;
          end
        end
        // Pulse shortened once ready drops inside it
        s_nxt.drv.hs_cmd = pulse_hi && !s_r.cut && hs_ready_in;
        s_nxt.drv.ls_cmd = !pulse_hi && ls_ready_in;
        if (trip) begin
          // Keeps third-quadrant time of the partner switch short
          s_nxt.cut = 1'b1;
          s_nxt.drv.hs_cmd = 1'b0;
          s_nxt.stat.fault_seen = 1'b1;
          s_nxt.cbc_run = s_r.cbc_run + 4'h1;
          if (cbc_limit_hit(s_r.cbc_run, ctrl_in.latched_variant)) begin
            s_nxt.timer = '0;
            s_nxt.st = S_CLEAR;
          end
        end
        if (!ctrl_in.enable) begin
          s_nxt.st = S_SLEEP;
        end
      end
      S_CLEAR: begin
        // Hold command low past the latch reset time
        s_nxt.stat.latched_shutdown = 1'b1;
        s_nxt.timer = s_r.timer + 14'h0001;
        // Restart soft: the output may be pre-biased by now
        if (clear_done) begin
          s_nxt.stat.latched_shutdown = 1'b0;
          s_nxt.cbc_run = '0;
          s_nxt.cut = 1'b0;
          s_nxt.timer = '0;
          s_nxt.phase = '0;
          s_nxt.duty = SOFT_START_DUTY;
          s_nxt.st = ctrl_in.enable ? S_SOFT : S_SLEEP;
        end
      end
      default: s_nxt.st = S_SLEEP;
    endcase

    if (s_nxt.st == S_SLEEP) begin
      s_nxt.cbc_run = '0;
      s_nxt.cut = 1'b0;
      s_nxt.stat.latched_shutdown = 1'b0;
    end
    // Shoot-through guard: never both switches on together
    if (s_nxt.drv.hs_cmd) begin
      s_nxt.drv.ls_cmd = 1'b0;
    end
    s_nxt.stat.running = (s_nxt.st == S_RUN);
    s_nxt.stat.starting = is_starting(s_nxt.st);
    s_nxt.stat.waking = (s_nxt.st == S_WAKE);
    // A trip in the disabling cycle still shows once: set wins
    if (!ctrl_in.enable && !trip) begin
      s_nxt.stat.fault_seen = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      // Devices start asleep with every command low
      s_r <= '{st: S_SLEEP, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign drive_out = s_r.drv;
  assign stat_out = s_r.stat;
endmodule

//--- test/psfp_dev_model.sv
module psfp_dev_model #(parameter int WAKE = 10000) (
  input wire logic clk_in,
  input wire logic lpr_in,
  input wire logic oc_in,
  output logic ready_out
);
  int cnt;
  always_ff @(posedge clk_in) begin
    if (!lpr_in) cnt <= 0;
    else if (cnt < WAKE) cnt <= cnt + 1;
  end
  // Push-pull, low until awake and fault-free
  // Trip, blanking and over-temperature folded into oc_in
  assign ready_out = (cnt == WAKE) && !oc_in;
endmodule

//--- test/psfp_ctrl_monitor.sv
module psfp_ctrl_monitor import psfp_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire psfp_ctrl_t ctrl_in,
  input wire logic hs_ready_in,
  input wire logic ls_ready_in,
  input wire psfp_drive_t drive_out,
  input wire psfp_stat_t stat_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence ready_drop_s;
    $past(drive_out.hs_cmd) && $fell(hs_ready_in);
  endsequence
  hold_low_side_a: assert property (stat_out.starting &&
    ctrl_in.mode == PSFP_BUCK && !hs_ready_in |-> !drive_out.hs_cmd)
    else $error("high side driven before ready");
  cut_pulse_a: assert property (
    ready_drop_s |-> ##[0:1] !drive_out.hs_cmd)
    else $error("pulse not cut on fault");
  speedup_gate_a: assert property (
    $rose(drive_out.speedup) |-> $past(hs_ready_in))
    else $error("speed-up before ready");
  soft_pulse_a: assert property ($rose(stat_out.starting) &&
    ctrl_in.mode == PSFP_BOOST |-> ##[1:8] !drive_out.ls_cmd)
    else $error("soft-start pulse too long");
endmodule
bind psfp_ctrl psfp_ctrl_monitor mon (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .ctrl_in(ctrl_in), .hs_ready_in(hs_ready_in), .ls_ready_in(ls_ready_in),
  .drive_out(drive_out), .stat_out(stat_out));

//--- test/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import psfp_pkg::*;
  logic clk_in = 0, rst_n_in = 0, hs_ready_in, ls_ready_in, oc = 0;
  psfp_ctrl_t ctrl = '0;
  psfp_drive_t drv;
  psfp_stat_t st;
  int miscompares = 0, check_count = 0, i, hi_count;
  // Enable level beside expected low-power pin
  logic [1:0] rows [3] = '{2'b11, 2'b00, 2'b11};
  initial forever #50 clk_in = ~clk_in;
  psfp_ctrl uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ctrl_in(ctrl),
    .hs_ready_in(hs_ready_in), .ls_ready_in(ls_ready_in),
    .drive_out(drv), .stat_out(st));
  psfp_dev_model hs (.clk_in(clk_in), .lpr_in(drv.low_power_request),
    .oc_in(oc), .ready_out(hs_ready_in));
  psfp_dev_model ls (.clk_in(clk_in), .lpr_in(drv.low_power_request),
    .oc_in(1'b0), .ready_out(ls_ready_in));
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // Bounded wait: starting, or running when run is set
  task wt(input bit run);
    int n;
    for (n = 0; n < 20000 && !(run ? st.running : st.starting); n++)
      @(negedge clk_in);
    if (n == 20000) begin
      miscompares++;
      report_and_stop;
    end
  endtask
  // Bounded wait until the high side is commanded on, returning at once if it already is
  task wt_hs;
    int n;
    for (n = 0; n < 200 && drv.hs_cmd !== 1'b1; n++)
      @(negedge clk_in);
    if (n == 200) begin
      miscompares++;
      report_and_stop;
    end
  endtask
  initial begin
    repeat (8) @(negedge clk_in);
    rst_n_in = 1;
    chk(8'(drv), 8'h00);
    foreach (rows[k]) begin
      ctrl.enable = rows[k][1];
      repeat (2) @(negedge clk_in);
      chk(8'(drv.low_power_request), 8'(rows[k][0]));
    end
    ctrl.duty = 8'h32;
    wt(0);
    @(negedge clk_in);
    chk(8'(drv.ls_cmd), 8'h01);
    chk(8'(drv.hs_cmd), 8'h00);
    wt(1);
    chk(8'(hs_ready_in), 8'h01);
    repeat (2) @(negedge clk_in);
    chk(8'(drv.speedup), 8'h01);
    wt_hs;
    oc = 1;
    repeat (2) @(negedge clk_in);
    chk(8'(drv.hs_cmd), 8'h00);
    chk(8'(drv.speedup), 8'h00);
    chk(8'(st.fault_seen), 8'h01);
    oc = 0;
    wt_hs;
    chk(8'(drv.hs_cmd), 8'h01);
    chk(8'(st.latched_shutdown), 8'h00);
    ctrl.latched_variant = 1;
    wt_hs;
    oc = 1;
    repeat (2) @(negedge clk_in);
    oc = 0;
    chk(8'(st.latched_shutdown), 8'h01);
    hi_count = 0;
    for (i = 0; i < 3400; i++) begin
      @(negedge clk_in);
      hi_count += int'(drv.hs_cmd);
    end
    chk(8'(hi_count), 8'h00);
    wt(0);
    chk(8'(st.latched_shutdown), 8'h00);
    ctrl.latched_variant = 0;
    ctrl.enable = 0;
    ctrl.mode = PSFP_BOOST;
    @(negedge clk_in);
    ctrl.enable = 1;
    wt(0);
    hi_count = 0;
    for (i = 0; i < 100; i++) begin
      @(negedge clk_in);
      hi_count += int'(drv.ls_cmd);
    end
    chk(8'(hi_count), SOFT_START_DUTY);
    chk(8'(drv.hs_cmd), 8'h00);
    wt(1);
    chk(8'(st.running), 8'h01);
    report_and_stop;
  end
endmodule
